// ### src/emif_pkg.sv
package emif_pkg;

  // memory mode encodings
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  // on-chip ram geometry: 4k bytes, addresses wrap on this size
  localparam int ONCHIP_AW = 12;
  localparam logic [15:0] ONCHIP_SIZE = 16'h1000;

  // fixed overhead of an off-chip access: one start cycle plus a tail
  localparam logic [3:0] TAIL_CYCLES = 4'h3;

  // multiplex select value that selects separate pins
  localparam logic MUX_SEPARATE = 1'b1;

  typedef struct packed {
    logic mux_sel;
    logic [1:0] mode;
    logic [1:0] latch_width;
  } mem_config_type;

  typedef struct packed {
    logic [1:0] setup;
    logic [3:0] strobe;
    logic [1:0] hold;
  } mem_timing_type;

  // reset values: non-multiplexed off, internal, widest latch strobe
  localparam mem_config_type CONFIG_RESET = '{
    mux_sel: 1'b0, mode: 2'h0, latch_width: 2'h3};
  // setup and hold at their maximum delay, widest strobe
  localparam mem_timing_type TIMING_RESET = '{
    setup: 2'h3, strobe: 4'hF, hold: 2'h3};

  typedef struct packed {
    logic write;
    logic form16;
    logic ptr_sel;
    logic [7:0] wdata;
  } xmove_req_type;

  typedef struct packed {
    logic write;
    logic hi_en;
    logic [15:0] addr;
    logic [7:0] wdata;
  } access_type;

endpackage : emif_pkg

// ### src/external_memory_interface.sv
// Contract
// - multiplexed mode shares one 8-bit port for data and low address, drives latch strobe
// - latch strobe high with low address first; address held for the latch low time after its fall, then phase two
// - phase two carries data on shared port while read or write strobe active
// - non-multiplexed mode uses separate address and data pins, no latch phase
// - internal-only mode sends all accesses on-chip, wrapping on 4k boundary
// - internal-only: 8-bit form uses page and pointer, 16-bit uses data pointer
// - split without bank select: below boundary on-chip, above off-chip
// - split no bank, 8-bit form: page decides, high byte undriven, low from pointer
// - split modes, 16-bit form: data pointer decides, all sixteen bits driven
// - split with bank select: below boundary on-chip, above off-chip
// - split bank, 8-bit off-chip: high byte from page, low from pointer
// - external-only mode sends every access off-chip, on-chip ram invisible
// - external-only, 8-bit form: page ignored, high byte undriven, low from pointer
// - external-only, 16-bit form: full address from data pointer, all bits driven
// - setup, hold, strobe and latch widths programmable in whole clock cycles
// - off-chip access lasts timing parameters plus five cycles, five minimum
// - multiplexed latch phase adds at least two cycles, seven minimum
// - setup and hold settings reset to their maximum delays
// - multiplex select cleared means multiplexed, set means separate pins
// - latch strobe high and low times are latch field plus one cycle
// - read and write strobe width is strobe field plus one cycle
module external_memory_interface
  import emif_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic config_load,
  input wire mem_config_type config_in,
  input wire logic timing_load,
  input wire mem_timing_type timing_in,
  input wire logic [7:0] xram_page_register,
  input wire logic [15:0] data_pointer,
  input wire logic [7:0] indirect_pointer_low,
  input wire logic [7:0] indirect_pointer_alt,
  input wire logic xmove_valid,
  input wire xmove_req_type xmove_req,
  input wire logic [7:0] ad_in,
  output mem_config_type memory_config_register,
  output mem_timing_type memory_timing_register,
  output logic busy,
  output logic done,
  output logic offchip,
  output logic [7:0] rdata,
  output logic [7:0] ad_out,
  output logic ad_oe,
  output logic [7:0] addr_lo_out,
  output logic addr_lo_oe,
  output logic [7:0] addr_hi_out,
  output logic addr_hi_oe,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic strobe_oe
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ONCHIP,
    ST_ONCHIP_DONE,
    ST_START,
    ST_ALE_HI,
    ST_ALE_LO,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_TAIL
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  mem_config_type cfg_q;
  mem_timing_type tim_q;
  access_type acc_q;
  access_type acc_d;
  logic busy_q;
  logic done_q;
  logic offchip_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] ad_q;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_hi_q;
  logic ad_oe_q;
  logic addr_lo_oe_q;
  logic addr_hi_oe_q;
  logic ale_q;
  logic rd_n_q;
  logic wr_n_q;
  logic stb_oe_q;

  // effective address and routing decode
  wire logic [7:0] ptr = xmove_req.ptr_sel ? indirect_pointer_alt
                                           : indirect_pointer_low;
  wire logic [15:0] eff_addr = xmove_req.form16 ? data_pointer
                                                : {xram_page_register, ptr};
  wire logic above_bound = eff_addr >= ONCHIP_SIZE;
  wire logic mode_int = cfg_q.mode == MODE_INTERNAL;
  wire logic mode_ext = cfg_q.mode == MODE_EXTERNAL;
  wire logic mode_bank = cfg_q.mode == MODE_SPLIT_BANK;
  // split modes route on the boundary, 8-bit form by page, 16-bit by pointer
  wire logic go_off = mode_ext | (~mode_int & above_bound);
  // high byte driven for 16-bit form always, 8-bit form only with bank select
  wire logic hi_drive = xmove_req.form16 | mode_bank;
  wire logic muxed = cfg_q.mux_sel != MUX_SEPARATE;

  // phase lengths for the down counter; setup and hold minus one, latch and strobe fields as is
  wire logic [3:0] ale_len = {2'h0, cfg_q.latch_width};
  wire logic [3:0] setup_len = {2'h0, tim_q.setup} - 4'h1;
  wire logic [3:0] strobe_len = tim_q.strobe;
  wire logic [3:0] hold_len = {2'h0, tim_q.hold} - 4'h1;
  wire logic setup_zero = tim_q.setup == 2'h0;
  wire logic hold_zero = tim_q.hold == 2'h0;
  wire logic cnt_zero = cnt_q == 4'h0;

  // pin phase decode
  wire logic drive_phase = state_q inside {ST_START, ST_ALE_HI, ST_ALE_LO,
                                          ST_SETUP, ST_STROBE, ST_HOLD};
  wire logic ale_high_phase = state_q == ST_ALE_HI;
  wire logic data_phase = state_q inside {ST_SETUP, ST_STROBE, ST_HOLD};
  wire logic in_strobe = state_q == ST_STROBE;
  wire logic ram_en = (state_q == ST_IDLE) & xmove_valid & ~go_off;

  logic [7:0] ram_rdata;

  onchip_xram u_ram (
    .mclk(mclk),
    .en(ram_en),
    .we(xmove_req.write),
    .addr(eff_addr[ONCHIP_AW-1:0]),
    .wdata(xmove_req.wdata),
    .rdata(ram_rdata)
  );

  // next pin values
  // latch strobe high only in its own phase, start cycle keeps it low
  wire logic ale_d = muxed & ale_high_phase;
  wire logic ad_oe_d = muxed ? (drive_phase & (~data_phase | acc_q.write))
                             : (data_phase & acc_q.write);
  wire logic [7:0] ad_d = (muxed & ~data_phase) ? acc_q.addr[7:0]
                                                 : acc_q.wdata;
  wire logic addr_lo_oe_d = ~muxed & drive_phase;
  wire logic addr_hi_oe_d = drive_phase & acc_q.hi_en;
  wire logic rd_n_d = ~(in_strobe & ~acc_q.write);
  wire logic wr_n_d = ~(in_strobe & acc_q.write);
  // read data is taken on the last edge with the read strobe pin low
  wire logic read_sample = ~rd_n_q & rd_n_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    rdata_d = rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (xmove_valid) begin
          acc_d.write = xmove_req.write;
          acc_d.hi_en = hi_drive;
          acc_d.addr = eff_addr;
          acc_d.wdata = xmove_req.wdata;
          cnt_d = 4'h0;
          state_d = go_off ? ST_START : ST_ONCHIP;
        end
      end
      ST_ONCHIP: begin
        state_d = ST_ONCHIP_DONE;
      end
      ST_ONCHIP_DONE: begin
        if (!acc_q.write) begin
          rdata_d = ram_rdata;
        end
        state_d = ST_IDLE;
      end
      ST_START: begin
        if (muxed) begin
          cnt_d = ale_len;
          state_d = ST_ALE_HI;
        end else if (!setup_zero) begin
          cnt_d = setup_len;
          state_d = ST_SETUP;
        end else begin
          cnt_d = strobe_len;
          state_d = ST_STROBE;
        end
      end
      ST_ALE_HI: begin
        if (cnt_zero) begin
          cnt_d = ale_len;
          state_d = ST_ALE_LO;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_ALE_LO: begin
        if (!cnt_zero) begin
          cnt_d = cnt_q - 4'h1;
        end else if (!setup_zero) begin
          cnt_d = setup_len;
          state_d = ST_SETUP;
        end else begin
          cnt_d = strobe_len;
          state_d = ST_STROBE;
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          cnt_d = strobe_len;
          state_d = ST_STROBE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_STROBE: begin
        if (!cnt_zero) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          if (!hold_zero) begin
            cnt_d = hold_len;
            state_d = ST_HOLD;
          end else begin
            cnt_d = TAIL_CYCLES - 4'h1;
            state_d = ST_TAIL;
          end
        end
      end
      ST_HOLD: begin
        if (cnt_zero) begin
          cnt_d = TAIL_CYCLES - 4'h1;
          state_d = ST_TAIL;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_TAIL: begin
        if (cnt_zero) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
    if (read_sample) begin
      rdata_d = ad_in;
    end
  end

  wire logic finishing = (state_q == ST_ONCHIP_DONE)
                       | ((state_q == ST_TAIL) & cnt_zero);
  wire logic busy_d = state_d != ST_IDLE;
  wire logic offchip_d = (state_q == ST_IDLE) ? (xmove_valid & go_off)
                                              : (offchip_q & busy_d);

  // configuration registers; setup and hold start at maximum delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CONFIG_RESET;
      tim_q <= TIMING_RESET;
    end else begin
      if (config_load) begin
        cfg_q <= config_in;
      end
      if (timing_load) begin
        tim_q <= timing_in;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      acc_q <= '0;
      rdata_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      offchip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      rdata_q <= rdata_d;
      busy_q <= busy_d;
      done_q <= finishing;
      offchip_q <= offchip_d;
    end
  end

  // pin registers; enables drop outside an off-chip access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ad_q <= 8'h00;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      ad_oe_q <= 1'b0;
      addr_lo_oe_q <= 1'b0;
      addr_hi_oe_q <= 1'b0;
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      stb_oe_q <= 1'b0;
    end else begin
      ad_q <= ad_d;
      addr_lo_q <= acc_q.addr[7:0];
      addr_hi_q <= acc_q.addr[15:8];
      ad_oe_q <= ad_oe_d;
      addr_lo_oe_q <= addr_lo_oe_d;
      addr_hi_oe_q <= addr_hi_oe_d;
      ale_q <= ale_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      stb_oe_q <= drive_phase;
    end
  end

  assign memory_config_register = cfg_q;
  assign memory_timing_register = tim_q;
  assign busy = busy_q;
  assign done = done_q;
  assign offchip = offchip_q;
  assign rdata = rdata_q;
  assign ad_out = ad_q;
  assign ad_oe = ad_oe_q;
  assign addr_lo_out = addr_lo_q;
  assign addr_lo_oe = addr_lo_oe_q;
  assign addr_hi_out = addr_hi_q;
  assign addr_hi_oe = addr_hi_oe_q;
  assign ale_out = ale_q;
  assign rd_n_out = rd_n_q;
  assign wr_n_out = wr_n_q;
  assign strobe_oe = stb_oe_q;

endmodule : external_memory_interface

// ### src/onchip_xram.sv
module onchip_xram
  import emif_pkg::*;
(
  input wire logic mclk,
  input wire logic en,
  input wire logic we,
  input wire logic [ONCHIP_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:(1<<ONCHIP_AW)-1];

  always_ff @(posedge mclk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en) begin
      rdata <= mem[addr];
    end
  end

endmodule : onchip_xram

// ### verif/emif_properties.sv
module emif_properties
  import emif_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire mem_config_type memory_config_register,
  input wire mem_timing_type memory_timing_register,
  input wire logic busy,
  input wire logic done,
  input wire logic offchip,
  input wire logic ad_oe,
  input wire logic addr_lo_oe,
  input wire logic addr_hi_oe,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic strobe_oe
);
  wire mem_config_type c = memory_config_register;
  wire mem_timing_type t = memory_timing_register;
  wire logic [5:0] lat_span = c.mux_sel ? 6'h0
    : {3'h0, c.latch_width, 1'b0} + 6'h2;
  wire logic [5:0] span = 6'h5 + {4'h0, t.setup} + {2'h0, t.strobe}
    + {4'h0, t.hold} + lat_span;
  logic [5:0] busy_q;
  logic [5:0] ale_q;
  logic [5:0] stb_q;
  logic off_q;
  // cycle counters of busy, latch strobe high and strobe low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 6'h0;
      ale_q <= 6'h0;
      stb_q <= 6'h0;
      off_q <= 1'b0;
    end else begin
      busy_q <= busy ? busy_q + 6'h1 : 6'h0;
      ale_q <= ale_out ? ale_q + 6'h1 : 6'h0;
      stb_q <= (!rd_n_out || !wr_n_out) ? stb_q + 6'h1 : 6'h0;
      off_q <= busy ? offchip : off_q;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence ale_fall;
    ale_out ##1 !ale_out;
  endsequence
  chk_sep_no_ale: assert property (c.mux_sel |-> !ale_out)
    else $error("latch strobe in separate-pin mode");
  chk_mux_no_lopins: assert property (!c.mux_sel |-> !addr_lo_oe)
    else $error("low address pins driven in multiplexed mode");
  chk_ale_drives_ad: assert property (ale_out |-> ad_oe)
    else $error("shared port idle while latch strobe high");
  chk_ale_low_addr: assert property (ale_fall |-> ad_oe && rd_n_out && wr_n_out)
    else $error("address not held after latch strobe fall");
  chk_ale_width: assert property ($fell(ale_out) |-> ale_q == {4'h0, c.latch_width} + 6'h1)
    else $error("latch strobe high time wrong");
  chk_strobe_width: assert property ($rose(rd_n_out && wr_n_out) |-> stb_q == {2'h0, t.strobe} + 6'h1)
    else $error("strobe width wrong");
  chk_write_data: assert property (!wr_n_out |-> ad_oe && strobe_oe)
    else $error("write strobe without data");
  chk_read_release: assert property (!rd_n_out |-> !ad_oe)
    else $error("data port driven during read");
  chk_offchip_len: assert property (done && off_q |-> busy_q == span)
    else $error("off-chip access length wrong");
  chk_onchip_len: assert property (done && !off_q |-> busy_q == 6'h2)
    else $error("on-chip access length wrong");
  chk_idle_release: assert property (!busy |-> !(ad_oe || addr_lo_oe || addr_hi_oe || strobe_oe))
    else $error("pins driven while idle");
  chk_mode_route: assert property ($rose(busy) && c.mode[1] == c.mode[0] |-> offchip == c.mode[0])
    else $error("routing wrong in fixed mode");
  chk_onchip_quiet: assert property (busy && !offchip |-> rd_n_out && wr_n_out && !strobe_oe)
    else $error("strobes during on-chip access");
endmodule : emif_properties

bind external_memory_interface emif_properties emif_properties_i (
  .mclk, .rst_n, .memory_config_register, .memory_timing_register, .busy,
  .done, .offchip, .ad_oe, .addr_lo_oe, .addr_hi_oe, .ale_out, .rd_n_out,
  .wr_n_out, .strobe_oe);

// ### verif/ext_sram_model.sv
module ext_sram_model
  import emif_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] addr_lo_out,
  input wire logic addr_lo_oe,
  input wire logic [7:0] addr_hi_out,
  input wire logic addr_hi_oe,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic strobe_oe,
  output logic [7:0] ad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [7:0] lat_q;
  logic [7:0] last_q = 8'h00;
  // undriven high address pins stay parked high by the port latches
  wire logic [15:0] a = {addr_hi_oe ? addr_hi_out : 8'hFF,
    addr_lo_oe ? addr_lo_out : lat_q};
  wire logic rd = strobe_oe && !rd_n_out;
  always_latch begin
    if (ale_out && strobe_oe) lat_q <= ad_out;
  end
  always @(posedge mclk) begin
    if (strobe_oe && !wr_n_out) mem[a] <= ad_out;
    if (rd) last_q <= ad_in;
  end
  // released bus shows the inverse of the last value
  assign ad_in = rd ? mem[a] : ~last_q;
endmodule : ext_sram_model

// ### verif/tb_top.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top
  import emif_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n, config_load, timing_load, xmove_valid;
  mem_config_type config_in, memory_config_register;
  mem_timing_type timing_in, memory_timing_register;
  xmove_req_type xmove_req;
  logic [7:0] xram_page_register, indirect_pointer_low, indirect_pointer_alt;
  logic [7:0] ad_in, rdata, ad_out, addr_lo_out, addr_hi_out, r;
  logic [15:0] data_pointer;
  logic busy, done, offchip, ad_oe, addr_lo_oe, addr_hi_oe;
  logic ale_out, rd_n_out, wr_n_out, strobe_oe, m_mux;
  logic [1:0] m_lw, m_su, m_hd;
  logic [3:0] m_st;
  int bad_count = 0, checked = 0;
  external_memory_interface external_memory_interface_i (.mclk, .rst_n,
    .config_load, .config_in, .timing_load, .timing_in, .xram_page_register,
    .data_pointer, .indirect_pointer_low, .indirect_pointer_alt,
    .xmove_valid, .xmove_req, .ad_in, .memory_config_register,
    .memory_timing_register, .busy, .done, .offchip, .rdata, .ad_out, .ad_oe,
    .addr_lo_out, .addr_lo_oe, .addr_hi_out, .addr_hi_oe, .ale_out,
    .rd_n_out, .wr_n_out, .strobe_oe);
  ext_sram_model ext_sram_model_i (.mclk, .ad_out, .addr_lo_out, .addr_lo_oe,
    .addr_hi_out, .addr_hi_oe, .ale_out, .rd_n_out, .wr_n_out, .strobe_oe,
    .ad_in);
  initial forever #5 mclk = ~mclk;
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task setcfg(input logic mx, input logic [1:0] md, lw, su,
      input logic [3:0] st, input logic [1:0] hd);
    {m_mux, m_lw, m_su, m_st, m_hd} = {mx, lw, su, st, hd};
    config_in = '{mux_sel: mx, mode: md, latch_width: lw};
    timing_in = '{setup: su, strobe: st, hold: hd};
    config_load = 1'b1;
    timing_load = 1'b1;
    @(posedge mclk);
    #1;
    config_load = 1'b0;
    timing_load = 1'b0;
  endtask : setcfg
  // unused data pointer or page, and the unselected pointer, get inverted values to expose wrong selection
  task xfer(input logic wr, f16, ps, input logic [15:0] a,
      input logic [7:0] wd, input logic off);
    int n;
    int e;
    e = off ? 5 + m_su + m_st + m_hd + (m_mux ? 0 : 2 * m_lw + 2) : 2;
    data_pointer = f16 ? a : ~a;
    xram_page_register = f16 ? ~a[15:8] : a[15:8];
    indirect_pointer_low = ps ? ~a[7:0] : a[7:0];
    indirect_pointer_alt = ps ? a[7:0] : ~a[7:0];
    xmove_req = '{write: wr, form16: f16, ptr_sel: ps, wdata: wd};
    xmove_valid = 1'b1;
    @(posedge mclk);
    #1;
    xmove_valid = 1'b0;
    `CHK(offchip, off)
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n, e)
    if (n >= 300) end_of_test();
    r = rdata;
  endtask : xfer
  initial begin
    {rst_n, config_load, timing_load, xmove_valid} = 4'h0;
    {config_in, timing_in, xmove_req} = '0;
    {xram_page_register, indirect_pointer_low, indirect_pointer_alt} = '0;
    data_pointer = 16'h0000;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    `CHK(memory_timing_register.setup, 2'h3)
    `CHK(memory_timing_register.hold, 2'h3)
    setcfg(1'b0, MODE_INTERNAL, 2'h0, 2'h0, 4'h0, 2'h0);
    xfer(1'b1, 1'b1, 1'b0, 16'h1005, 8'h5A, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 16'h0005, 8'h00, 1'b0);
    `CHK(r, 8'h5A)
    xfer(1'b1, 1'b0, 1'b1, 16'h0234, 8'h3C, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 16'h0234, 8'h00, 1'b0);
    `CHK(r, 8'h3C)
    setcfg(1'b1, MODE_EXTERNAL, 2'h0, 2'h0, 4'h0, 2'h0);
    xfer(1'b1, 1'b1, 1'b0, 16'h0012, 8'hA5, 1'b1);
    `CHK(ext_sram_model_i.mem[16'h0012], 8'hA5)
    xfer(1'b0, 1'b1, 1'b0, 16'h0012, 8'h00, 1'b1);
    `CHK(r, 8'hA5)
    xfer(1'b1, 1'b0, 1'b0, 16'h1256, 8'h66, 1'b1);
    `CHK(ext_sram_model_i.mem[16'hFF56], 8'h66)
    setcfg(1'b1, MODE_SPLIT_NOBANK, 2'h0, 2'h1, 4'h2, 2'h3);
    xfer(1'b1, 1'b1, 1'b0, 16'h0100, 8'h11, 1'b0);
    xfer(1'b1, 1'b1, 1'b0, 16'h2345, 8'h22, 1'b1);
    `CHK(ext_sram_model_i.mem[16'h2345], 8'h22)
    xfer(1'b1, 1'b0, 1'b1, 16'h2011, 8'h33, 1'b1);
    `CHK(ext_sram_model_i.mem[16'hFF11], 8'h33)
    xfer(1'b0, 1'b0, 1'b0, 16'h0100, 8'h00, 1'b0);
    `CHK(r, 8'h11)
    setcfg(1'b0, MODE_SPLIT_BANK, 2'h1, 2'h1, 4'h2, 2'h1);
    xfer(1'b1, 1'b0, 1'b0, 16'h2022, 8'h44, 1'b1);
    `CHK(ext_sram_model_i.mem[16'h2022], 8'h44)
    xfer(1'b0, 1'b0, 1'b0, 16'h2022, 8'h00, 1'b1);
    `CHK(r, 8'h44)
    xfer(1'b1, 1'b1, 1'b0, 16'h0FFF, 8'h55, 1'b0);
    xfer(1'b1, 1'b1, 1'b0, 16'h1000, 8'h77, 1'b1);
    `CHK(ext_sram_model_i.mem[16'h1000], 8'h77)
    setcfg(1'b0, MODE_SPLIT_BANK, 2'h0, 2'h0, 4'h0, 2'h0);
    xfer(1'b1, 1'b1, 1'b0, 16'hABCD, 8'h99, 1'b1);
    `CHK(ext_sram_model_i.mem[16'hABCD], 8'h99)
    end_of_test();
  end
endmodule : tb_top
